// *** hw/lin_defines.vh ***
// Purpose: Shared constants for the four-channel LIN mode control block
// Assumes: 100 MHz clock; times are given in microseconds
// Notes: Mode and chip-mode codes are shared with the software view
`ifndef LIN_DEFINES_VH
`define LIN_DEFINES_VH

`define CLK_MHZ          100
`define CNT_W            24

`define MODE_OFF         2'h0
`define MODE_WAKE        2'h1
`define MODE_RXONLY      2'h2
`define MODE_NORMAL      2'h3

`define SBC_NORMAL       3'h0
`define SBC_STOP         3'h1
`define SBC_SLEEP        3'h2
`define SBC_RESTART      3'h3
`define SBC_FAILSAFE     3'h4

`define WAKE_FILT_MIN_US 30
`define WAKE_FILT_MAX_US 150
`define WAKE_FILT_CYC    (`WAKE_FILT_MIN_US * `CLK_MHZ)
`define EN_TIME_US       10
`define EN_CYC           (`EN_TIME_US * `CLK_MHZ)
`define DOM_TO_US        20000
`define DOM_TO_CYC_DEF   24'h1e8480

`endif

// *** hw/lin_sync.v ***
// Purpose: Two-flop synchroniser for asynchronous pin inputs
// Assumes: Inputs change slowly relative to the clock
// Notes: First stage feeds only the second stage
`timescale 1ns/1ns
module lin_sync #(
	parameter W    = 1,
	parameter [W-1:0] INIT = {W{1'b0}}
) (
	input  wire         clock,    // System clock
	input  wire         reset_n,  // Synchronous reset, active low
	input  wire         clock_en, // Freezes state when low
	input  wire [W-1:0] async_in, // Pin levels
	output reg  [W-1:0] sync_out  // Synchronised levels
);
	reg [W-1:0] meta_reg;

	always @(posedge clock) begin
		if (!reset_n) begin
			meta_reg <= INIT;
			sync_out <= INIT;
		end else if (clock_en) begin
			meta_reg <= async_in;
			sync_out <= meta_reg;
		end
	end
endmodule

// *** hw/lin_transceiver_mode_control.v ***
// Purpose: Mode control, wake detection and fault logic for four LIN channels
// Assumes: Chip mode and SPI strobes come from logic on the same clock
// Notes: Bus and pin levels are high for recessive, low for dominant
`timescale 1ns/1ns
`include "lin_defines.vh"
module lin_transceiver_mode_control #(
	parameter [`CNT_W-1:0] DOM_TO_CYC = `DOM_TO_CYC_DEF
) (
	input  wire       clock,                // 100 MHz system clock
	input  wire       reset_n,              // Synchronous reset, active low
	input  wire       clock_en,             // Freezes all state when low
	input  wire [2:0] sbc_mode,             // Current chip mode
	input  wire       sbc_mode_cmd,         // Pulse: chip commanded into sbc_mode
	input  wire [3:0] mode_wr,              // Pulse per channel: write mode
	input  wire [1:0] mode_wdata,           // Mode code to write
	input  wire [3:0] fail_clr,             // Pulse per channel: clear fail flag
	input  wire [3:0] wake_status_clr,      // Pulse per channel: clear wake status
	input  wire       tx_timeout_disable,   // Disables transmit time-out
	input  wire       slope_wr,             // Pulse: write low-slope bit
	input  wire       slope_wdata,          // Low-slope value to write
	input  wire       spi_chip_select_n,    // SPI chip select pin
	input  wire       watchdog_on_bus_wake, // Enable watchdog on Stop bus wake
	input  wire       watchdog_enabled,     // Watchdog currently enabled
	input  wire [3:0] transmit_in,          // Transmit pins from controller
	input  wire [3:0] bus_level,            // Receiver comparator levels
	input  wire       vlin_uv,              // Bus supply undervoltage
	output wire [1:0] channel1_mode_field,  // Channel 1 mode
	output wire [1:0] channel2_mode_field,  // Channel 2 mode
	output wire [1:0] channel3_mode_field,  // Channel 3 mode
	output wire [1:0] channel4_mode_field,  // Channel 4 mode
	output wire       channel1_fail_flag,   // Channel 1 fail
	output wire       channel2_fail_flag,   // Channel 2 fail
	output wire       channel3_fail_flag,   // Channel 3 fail
	output wire       channel4_fail_flag,   // Channel 4 fail
	output wire [3:0] wake_status_reg2,     // Sticky bus wake per channel
	output wire [3:0] receive_out,          // Receive pins to controller
	output wire [3:0] bus_dominant,         // Driver pulls bus dominant
	output wire [3:0] driver_enable,        // Output stage enabled
	output reg        bus_wake_int_n,       // Interrupt pulse, active low
	output reg        restart_request,      // Pulse: chip to Restart
	output reg        watchdog_enable_set,  // Pulse: enable watchdog
	output reg        low_slope_select      // Low slope for all channels
);
	localparam CW = `CNT_W;
	localparam [31:0] WAKE_CYC32 = `WAKE_FILT_CYC;
	localparam [31:0] EN_CYC32   = `EN_CYC;
	localparam [CW-1:0] WAKE_CYC = WAKE_CYC32[CW-1:0];
	localparam [CW-1:0] EN_CYC   = EN_CYC32[CW-1:0];
	localparam [CW-1:0] CNT_MAX  = {CW{1'b1}};

	function mode_allowed;
		input [1:0] m;
		input [2:0] s;
		begin
			case (m)
				`MODE_OFF:    mode_allowed = 1'b1;
				`MODE_NORMAL: mode_allowed = (s == `SBC_NORMAL);
				`MODE_RXONLY: mode_allowed = (s == `SBC_NORMAL) || (s == `SBC_STOP);
				`MODE_WAKE:   mode_allowed = (s != `SBC_FAILSAFE);
				default:      mode_allowed = 1'b0;
			endcase
		end
	endfunction

	function rearm_mode;
		input [2:0] s;
		begin
			rearm_mode = (s == `SBC_STOP) || (s == `SBC_SLEEP) ||
			             (s == `SBC_FAILSAFE);
		end
	endfunction

	wire [3:0] tx_s;
	wire [3:0] bus_s;
	wire       uv_s;
	wire       csn_s;
	wire       uv_n_s;

	lin_sync #(
		.W    (10),
		.INIT (10'h3ff)
	) u_sync (
		.clock    (clock),
		.reset_n  (reset_n),
		.clock_en (clock_en),
		.async_in ({spi_chip_select_n, ~vlin_uv, bus_level, transmit_in}),
		.sync_out ({csn_s, uv_n_s, bus_s, tx_s})
	);
	assign uv_s = ~uv_n_s;

	wire       fs_entry = sbc_mode_cmd && (sbc_mode == `SBC_FAILSAFE);
	wire       rearm    = sbc_mode_cmd && rearm_mode(sbc_mode);
	wire [3:0] wake_evt;
	wire [7:0] mode_vec;
	wire [3:0] fail_vec;

	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_ch
			reg  [1:0]    mode_reg;
			reg           armed_reg;
			reg           woken_reg;
			reg           fell_reg;
			reg           bus_prev_reg;
			reg  [CW-1:0] bus_cnt_reg;
			reg  [CW-1:0] en_cnt_reg;
			reg           tx_arm_reg;
			reg  [CW-1:0] tx_cnt_reg;
			reg           to_reg;
			reg           fail_reg;
			reg           wstat_reg;
			reg           rx_reg;
			reg           drv_reg;
			reg           drv_en_reg;
			reg  [1:0]    mode_next;
			reg           woken_next;
			reg           rx_next;
			wire          wr_ok;
			wire          bus_fall;
			wire          bus_rise;
			wire          is_normal;
			wire          en_done;
			wire          tx_to_evt;
			wire          clamp_evt;
			wire          drv_ok;

			assign wr_ok     = mode_wr[i] && mode_allowed(mode_wdata, sbc_mode);
			assign bus_fall  = bus_prev_reg && !bus_s[i];
			assign bus_rise  = !bus_prev_reg && bus_s[i];
			assign is_normal = (mode_reg == `MODE_NORMAL);
			assign en_done   = (en_cnt_reg >= EN_CYC);

			// Only a rising bus edge after a filtered dominant counts as wake
			assign wake_evt[i] = (mode_reg == `MODE_WAKE) && armed_reg && fell_reg &&
			                     bus_rise && (bus_cnt_reg >= WAKE_CYC);
			assign tx_to_evt = is_normal && !tx_timeout_disable && !tx_s[i] &&
			                   (tx_cnt_reg == DOM_TO_CYC);
			assign clamp_evt = (is_normal || (mode_reg == `MODE_RXONLY)) &&
			                   !bus_s[i] && (bus_cnt_reg == DOM_TO_CYC);
			// Next mode keeps the driver from lagging a mode change by a cycle
			assign drv_ok = (mode_next == `MODE_NORMAL) && tx_arm_reg && !to_reg &&
			                !uv_s;

			always @* begin
				mode_next = mode_reg;
				if (fs_entry)
					mode_next = `MODE_WAKE;
				else if (wr_ok)
					mode_next = mode_wdata;
				woken_next = woken_reg;
				if (rearm || (mode_next != `MODE_WAKE))
					woken_next = 1'b0;
				else if (wake_evt[i])
					woken_next = 1'b1;
				case (mode_next)
					`MODE_NORMAL: rx_next = bus_s[i];
					`MODE_RXONLY: rx_next = bus_s[i];
					`MODE_WAKE:   rx_next = ~woken_next;
					default:      rx_next = 1'b1;
				endcase
			end

			always @(posedge clock) begin
				if (!reset_n) begin
					mode_reg     <= `MODE_OFF;
					armed_reg    <= 1'b0;
					woken_reg    <= 1'b0;
					fell_reg     <= 1'b0;
					bus_prev_reg <= 1'b1;
					bus_cnt_reg  <= {CW{1'b0}};
					en_cnt_reg   <= {CW{1'b0}};
					tx_arm_reg   <= 1'b0;
					tx_cnt_reg   <= {CW{1'b0}};
					to_reg       <= 1'b0;
					fail_reg     <= 1'b0;
					wstat_reg    <= 1'b0;
					rx_reg       <= 1'b1;
					drv_reg      <= 1'b0;
					drv_en_reg   <= 1'b0;
				end else if (clock_en) begin
					mode_reg     <= mode_next;
					woken_reg    <= woken_next;
					bus_prev_reg <= bus_s[i];
					rx_reg       <= rx_next;
					if (rearm)
						armed_reg <= 1'b1;
					else if ((mode_next == `MODE_WAKE) && (mode_reg != `MODE_WAKE))
						armed_reg <= 1'b1;
					else if (wake_evt[i])
						armed_reg <= 1'b0;

					if (mode_reg != `MODE_WAKE || !armed_reg || bus_s[i])
						fell_reg <= 1'b0;
					else if (bus_fall)
						fell_reg <= 1'b1;

					if (bus_s[i])
						bus_cnt_reg <= {CW{1'b0}};
					else if (bus_cnt_reg != CNT_MAX)
						bus_cnt_reg <= bus_cnt_reg + 1'b1;

					if (mode_next != `MODE_NORMAL)
						en_cnt_reg <= {CW{1'b0}};
					else if (!en_done)
						en_cnt_reg <= en_cnt_reg + 1'b1;

					// An early low is discarded until transmit returns high
					if (mode_next != `MODE_NORMAL)
						tx_arm_reg <= 1'b0;
					else if (en_done && tx_s[i])
						tx_arm_reg <= 1'b1;

					if (tx_s[i] || !is_normal || tx_timeout_disable)
						tx_cnt_reg <= {CW{1'b0}};
					else if (tx_cnt_reg != CNT_MAX)
						tx_cnt_reg <= tx_cnt_reg + 1'b1;

					if (tx_s[i] || tx_timeout_disable)
						to_reg <= 1'b0;
					else if (tx_to_evt)
						to_reg <= 1'b1;

					if (tx_to_evt || clamp_evt)
						fail_reg <= 1'b1;
					else if (fail_clr[i])
						fail_reg <= 1'b0;

					if (wake_evt[i])
						wstat_reg <= 1'b1;
					else if (wake_status_clr[i])
						wstat_reg <= 1'b0;

					drv_reg    <= drv_ok && !tx_s[i];
					drv_en_reg <= drv_ok;
				end
			end

			assign mode_vec[2*i+1:2*i] = mode_reg;
			assign fail_vec[i]         = fail_reg;
			assign wake_status_reg2[i] = wstat_reg;
			assign receive_out[i]      = rx_reg;
			assign bus_dominant[i]     = drv_reg;
			assign driver_enable[i]    = drv_en_reg;
		end
	endgenerate

	assign channel1_mode_field = mode_vec[1:0];
	assign channel2_mode_field = mode_vec[3:2];
	assign channel3_mode_field = mode_vec[5:4];
	assign channel4_mode_field = mode_vec[7:6];
	assign channel1_fail_flag  = fail_vec[0];
	assign channel2_fail_flag  = fail_vec[1];
	assign channel3_fail_flag  = fail_vec[2];
	assign channel4_fail_flag  = fail_vec[3];

	wire any_wake  = |wake_evt;
	wire in_awake  = (sbc_mode == `SBC_NORMAL) || (sbc_mode == `SBC_STOP);
	wire in_asleep = (sbc_mode == `SBC_SLEEP) || (sbc_mode == `SBC_RESTART) ||
	                 (sbc_mode == `SBC_FAILSAFE);

	reg slope_pend_reg;
	reg csn_prev_reg;

	always @(posedge clock) begin
		if (!reset_n) begin
			bus_wake_int_n      <= 1'b1;
			restart_request     <= 1'b0;
			watchdog_enable_set <= 1'b0;
			low_slope_select    <= 1'b0;
			slope_pend_reg      <= 1'b0;
			csn_prev_reg        <= 1'b1;
		end else if (clock_en) begin
			// Chip mode itself is left to the supply state machine
			bus_wake_int_n      <= ~(any_wake && in_awake);
			restart_request     <= any_wake && in_asleep;
			watchdog_enable_set <= any_wake && (sbc_mode == `SBC_STOP) &&
			                       watchdog_on_bus_wake && !watchdog_enabled;
			csn_prev_reg        <= csn_s;
			if (slope_wr && (sbc_mode == `SBC_NORMAL))
				slope_pend_reg <= slope_wdata;
			// Applying on chip-select release avoids a slew change mid-frame
			if (csn_s && !csn_prev_reg)
				low_slope_select <= slope_pend_reg;
		end
	end
endmodule

// *** dv/lin_mode_properties.sv ***
// Purpose: Port-level properties for the LIN mode control block
// Assumes: One clock, synchronous active-low reset
// Notes: Channel 1 is watched, and all four drivers in undervoltage; the others share its logic
`timescale 1ns/1ns
`include "lin_defines.vh"
module lin_mode_props (
	input wire       clock,                // Clock
	input wire       reset_n,              // Reset
	input wire [2:0] sbc_mode,             // Chip mode
	input wire       sbc_mode_cmd,         // Mode command
	input wire [3:0] mode_wr,              // Mode write
	input wire [1:0] mode_wdata,           // Mode code
	input wire       watchdog_on_bus_wake, // Config
	input wire       watchdog_enabled,     // Status
	input wire       vlin_uv,              // Undervoltage
	input wire [1:0] channel1_mode_field,  // Mode
	input wire [3:0] wake_status_reg2,     // Wake status
	input wire [3:0] receive_out,          // Receive pins
	input wire [3:0] bus_dominant,         // Driver
	input wire [3:0] driver_enable,        // Stage on
	input wire       bus_wake_int_n,       // Interrupt
	input wire       restart_request,      // Restart
	input wire       watchdog_enable_set   // Watchdog on
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	property p_off_idle;
		channel1_mode_field == `MODE_OFF |-> !driver_enable[0];
	endproperty
	a_off_idle: assert property (p_off_idle) else $error("driver on in off");
	property p_normal_gate;
		mode_wr[0] && mode_wdata == `MODE_NORMAL && sbc_mode != `SBC_NORMAL && !sbc_mode_cmd
			|=> $stable(channel1_mode_field);
	endproperty
	a_normal_gate: assert property (p_normal_gate) else $error("normal taken");
	property p_rx_quiet;
		channel1_mode_field == `MODE_RXONLY |-> !bus_dominant[0];
	endproperty
	a_rx_quiet: assert property (p_rx_quiet) else $error("rx-only drives");
	property p_off_rx_high;
		channel1_mode_field == `MODE_OFF && $past(channel1_mode_field) == `MODE_OFF
			|-> receive_out[0];
	endproperty
	a_off_rx_high: assert property (p_off_rx_high) else $error("off not high");
	property p_wake_rx;
		$rose(wake_status_reg2[0]) |-> !receive_out[0] && channel1_mode_field == `MODE_WAKE;
	endproperty
	a_wake_rx: assert property (p_wake_rx) else $error("wake signalling");
	property p_int_modes;
		$fell(bus_wake_int_n) |-> $past(sbc_mode) inside {`SBC_NORMAL, `SBC_STOP};
	endproperty
	a_int_modes: assert property (p_int_modes) else $error("int in wrong mode");
	property p_restart_modes;
		restart_request |-> bus_wake_int_n && !($past(sbc_mode) inside {`SBC_NORMAL, `SBC_STOP});
	endproperty
	a_restart_modes: assert property (p_restart_modes) else $error("bad restart");
	property p_int_pulse;
		!bus_wake_int_n |=> bus_wake_int_n;
	endproperty
	a_int_pulse: assert property (p_int_pulse) else $error("int too long");
	property p_wd;
		watchdog_enable_set |-> $past(sbc_mode) == `SBC_STOP && $past(watchdog_on_bus_wake)
			&& !$past(watchdog_enabled);
	endproperty
	a_wd: assert property (p_wd) else $error("watchdog set wrongly");
	property p_uv;
		vlin_uv [*4] |-> bus_dominant == 4'h0 && driver_enable == 4'h0;
	endproperty
	a_uv: assert property (p_uv) else $error("driver on in undervoltage");
	c_int: cover property (!bus_wake_int_n);
	c_restart: cover property (restart_request);
	c_drive: cover property (bus_dominant[0]);
endmodule
bind lin_transceiver_mode_control lin_mode_props u_props (.clock, .reset_n, .sbc_mode,
	.sbc_mode_cmd, .mode_wr, .mode_wdata, .watchdog_on_bus_wake, .watchdog_enabled, .vlin_uv,
	.channel1_mode_field, .wake_status_reg2, .receive_out, .bus_dominant, .driver_enable,
	.bus_wake_int_n, .restart_request, .watchdog_enable_set);

// *** dv/lin_ctrl_model.sv ***
// Purpose: Controller transmit side of one LIN channel
// Assumes: Mode field tells when the transceiver was enabled
// Notes: early lets a scenario pull low before the enable time
`timescale 1ns/1ns
`include "lin_defines.vh"
module lin_ctrl_model #(
	parameter EN_WAIT = `EN_CYC + 10
) (
	input  wire       clock,   // Clock
	input  wire       reset_n, // Reset
	input  wire [1:0] mode,    // Channel mode
	input  wire       want,    // Level wanted
	input  wire       early,   // Break the wait
	output reg        tx       // Transmit pin
);
	reg [15:0] wait_reg;
	always @(posedge clock) begin
		if (!reset_n || mode != `MODE_NORMAL) begin
			wait_reg <= 16'h0000;
			tx <= 1'b1;
		end else begin
			if (wait_reg != EN_WAIT)
				wait_reg <= wait_reg + 16'h0001;
			tx <= (wait_reg == EN_WAIT || early) ? want : 1'b1;
		end
	end
endmodule

// *** dv/lin_transceiver_mode_control_tb_top.sv ***
// Purpose: Directed bench for the LIN mode control block
// Assumes: Short dominant time-out of 200 cycles
// Notes: Channel 1 is exercised, the rest stay recessive
`timescale 1ns/1ns
`include "lin_defines.vh"
module lin_transceiver_mode_control_tb_top;
	reg        clock = 1'b0, reset_n = 1'b0, cmd = 1'b0, tto = 1'b0, cs_n = 1'b1;
	reg        wdb = 1'b0, wde = 1'b0, uv = 1'b0, want = 1'b1, early = 1'b0;
	reg  [2:0] sbc = 3'h0;
	reg  [3:0] wr = 4'h0, bus = 4'hf, fclr = 4'h0;
	reg        swr = 1'b0, swd = 1'b0;
	reg  [1:0] wd = 2'h0;
	wire       tx0, fail1, int_n, rst_rq, wd_set, slope;
	wire [1:0] mode1;
	wire [3:0] ws, rx, dom, den;
	integer    n_mismatch = 0, tests_run = 0;
	reg        i_seen, r_seen, w_seen;
	always #5 clock = ~clock;
	lin_transceiver_mode_control #(.DOM_TO_CYC(24'h0000c8)) dut (.clock(clock),
		.reset_n(reset_n), .clock_en(1'b1), .sbc_mode(sbc), .sbc_mode_cmd(cmd), .mode_wr(wr),
		.mode_wdata(wd), .fail_clr(fclr), .wake_status_clr(4'h0), .tx_timeout_disable(tto),
		.slope_wr(swr), .slope_wdata(swd), .spi_chip_select_n(cs_n),
		.watchdog_on_bus_wake(wdb), .watchdog_enabled(wde), .transmit_in({3'h7, tx0}),
		.bus_level(bus), .vlin_uv(uv), .channel1_mode_field(mode1), .channel2_mode_field(),
		.channel3_mode_field(), .channel4_mode_field(), .channel1_fail_flag(fail1),
		.channel2_fail_flag(), .channel3_fail_flag(), .channel4_fail_flag(),
		.wake_status_reg2(ws), .receive_out(rx), .bus_dominant(dom), .driver_enable(den),
		.bus_wake_int_n(int_n), .restart_request(rst_rq), .watchdog_enable_set(wd_set),
		.low_slope_select(slope));
	lin_ctrl_model u_ctrl (.clock(clock), .reset_n(reset_n), .mode(mode1), .want(want),
		.early(early), .tx(tx0));
	task chk(input [63:0] nm, input [3:0] seen, input [3:0] exp);
		begin
			tests_run = tests_run + 1;
			if (seen !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("Error %0s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task cyc(input integer n);
		begin
			repeat (n) @(posedge clock);
			#1;
		end
	endtask
	task wmode(input [1:0] m);
		begin
			@(posedge clock) wr <= 4'h1;
			wd <= m;
			@(posedge clock) wr <= 4'h0;
			cyc(2);
		end
	endtask
	task chip(input [2:0] s);
		begin
			@(posedge clock) sbc <= s;
			cmd <= 1'b1;
			@(posedge clock) cmd <= 1'b0;
		end
	endtask
	task pulse(input integer len);
		begin
			@(posedge clock) bus <= 4'he;
			repeat (len) @(posedge clock);
			bus <= 4'hf;
			{i_seen, r_seen, w_seen} = 3'h0;
			repeat (8) begin
				cyc(1);
				if (int_n === 1'b0) i_seen = 1'b1;
				if (rst_rq === 1'b1) r_seen = 1'b1;
				if (wd_set === 1'b1) w_seen = 1'b1;
			end
		end
	endtask
	task t_reset;
		begin
			chk("mode", mode1, `MODE_OFF);
			chk("rx", rx, 4'hf);
			chk("slope", slope, 1'b0);
		end
	endtask
	task t_gate;
		begin
			chip(`SBC_STOP);
			wmode(`MODE_NORMAL);
			chk("mode", mode1, `MODE_OFF);
			wmode(`MODE_RXONLY);
			chk("mode", mode1, `MODE_RXONLY);
			chip(`SBC_NORMAL);
		end
	endtask
	task t_slope;
		begin
			@(posedge clock) swr <= 1'b1;
			swd <= 1'b1;
			@(posedge clock) swr <= 1'b0;
			cyc(4);
			chk("slope", slope, 1'b0);
			@(posedge clock) cs_n <= 1'b0;
			@(posedge clock) cs_n <= 1'b1;
			cyc(5);
			chk("slope", slope, 1'b1);
			chip(`SBC_STOP);
			@(posedge clock) swr <= 1'b1;
			swd <= 1'b0;
			@(posedge clock) swr <= 1'b0;
			@(posedge clock) cs_n <= 1'b0;
			@(posedge clock) cs_n <= 1'b1;
			cyc(5);
			chk("slope", slope, 1'b1);
			chip(`SBC_NORMAL);
		end
	endtask
	task t_tx;
		begin
			// Time-out off first, so only the enable gating can hold the driver
			tto <= 1'b1;
			early <= 1'b1;
			want <= 1'b0;
			wmode(`MODE_NORMAL);
			cyc(1100);
			chk("dom", dom[0], 1'b0);
			chk("fail", fail1, 1'b0);
			want <= 1'b1;
			cyc(5);
			tto <= 1'b0;
			want <= 1'b0;
			cyc(6);
			chk("dom", dom[0], 1'b1);
			cyc(220);
			chk("dom", dom[0], 1'b0);
			chk("den", den[0], 1'b0);
			chk("fail", fail1, 1'b1);
			want <= 1'b1;
			cyc(6);
			chk("den", den[0], 1'b1);
			@(posedge clock) fclr <= 4'h1;
			@(posedge clock) fclr <= 4'h0;
			cyc(1);
			chk("fail", fail1, 1'b0);
			tto <= 1'b1;
			want <= 1'b0;
			cyc(260);
			chk("dom", dom[0], 1'b1);
			@(posedge clock) uv <= 1'b1;
			cyc(6);
			chk("uv_den", den, 4'h0);
			chk("uv_mode", mode1, `MODE_NORMAL);
			@(posedge clock) uv <= 1'b0;
			cyc(6);
			chk("dom", dom[0], 1'b1);
			want <= 1'b1;
		end
	endtask
	task t_wake;
		begin
			wmode(`MODE_WAKE);
			pulse(2000);
			chk("short", {i_seen, r_seen}, 2'h0);
			pulse(3100);
			chk("int", {i_seen, r_seen}, 2'h2);
			chk("rx", rx[0], 1'b0);
			chk("stat", ws[0], 1'b1);
			chk("mode", mode1, `MODE_WAKE);
			pulse(3100);
			chk("again", {i_seen, r_seen}, 2'h0);
			wdb <= 1'b1;
			chip(`SBC_STOP);
			pulse(3100);
			chk("stop", {i_seen, r_seen, w_seen}, 3'h5);
			chip(`SBC_SLEEP);
			pulse(3100);
			chk("sleep", {i_seen, r_seen}, 2'h1);
			wmode(`MODE_OFF);
			chk("rx", rx[0], 1'b1);
			pulse(3100);
			chk("off", {i_seen, r_seen}, 2'h0);
			wmode(`MODE_WAKE);
			pulse(3100);
			chk("rearm", {i_seen, r_seen}, 2'h1);
		end
	endtask
	task tally_and_finish;
		begin
			if (n_mismatch == 0 && tests_run > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	initial begin
		repeat (5) @(posedge clock);
		reset_n <= 1'b1;
		cyc(1);
		t_reset;
		t_gate;
		t_slope;
		t_tx;
		t_wake;
		tally_and_finish;
	end
endmodule
